// ### hw/uce_pkg.sv
package uce_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFS_STATUS = 12'h104;
  localparam logic [11:0] OFS_MASK = 12'h108;
  localparam logic [11:0] OFS_SEV = 12'h10C;
  localparam logic [11:0] OFS_IRQ_STS = 12'h200;
  localparam logic [11:0] OFS_IRQ_MSK = 12'h204;

  // ****************************************
  // Error bit positions
  // ****************************************
  localparam int BIT_LEGACY = 0;
  localparam int BIT_LINK = 4;
  localparam int BIT_SURPRISE = 5;
  localparam int BIT_POISON = 12;
  localparam int BIT_CREDIT = 13;
  localparam int BIT_CPL_TO = 14;
  localparam int BIT_CPL_ABORT = 15;
  localparam int BIT_UNEXP_CPL = 16;
  localparam int BIT_OVERRUN = 17;
  localparam int BIT_MALFORMED = 18;
  localparam int BIT_ECRC = 19;
  localparam int BIT_UNSUP = 20;

  typedef logic [31:0] uce_word_t;

  // Error types that are detected, logged and reported.
  localparam uce_word_t EVT_IMPL = (32'h0000_0001 << BIT_LINK)
    | (32'h0000_0001 << BIT_SURPRISE) | (32'h0000_0001 << BIT_POISON)
    | (32'h0000_0001 << BIT_CREDIT) | (32'h0000_0001 << BIT_UNEXP_CPL)
    | (32'h0000_0001 << BIT_OVERRUN) | (32'h0000_0001 << BIT_MALFORMED)
    | (32'h0000_0001 << BIT_ECRC) | (32'h0000_0001 << BIT_UNSUP);
  localparam uce_word_t CTL_WMASK = EVT_IMPL
    | (32'h0000_0001 << BIT_LEGACY);

  // ****************************************
  // Reset values
  // ****************************************
  localparam uce_word_t MASK_RST = 32'h0000_0000;
  localparam uce_word_t STS_RST = 32'h0000_0000;
  localparam uce_word_t SEV_RST = (32'h0000_0001 << BIT_LINK)
    | (32'h0000_0001 << BIT_SURPRISE) | (32'h0000_0001 << BIT_CREDIT)
    | (32'h0000_0001 << BIT_OVERRUN) | (32'h0000_0001 << BIT_MALFORMED);

  // ****************************************
  // Interrupt status layout
  // ****************************************
  localparam int IRQ_FATAL = 0;
  localparam int IRQ_NONFATAL = 1;
  localparam int IRQ_W = 2;
  localparam logic [1:0] IRQ_RST = 2'h0;

  typedef struct packed {
    logic fatal;
    logic nonfatal;
  } uce_report_s;

  typedef struct packed {
    logic read;
    logic write;
    logic [11:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } uce_avmm_req_s;

  typedef enum logic {
    UCE_IDLE = 1'b0,
    UCE_ACK = 1'b1
  } uce_bus_e;

endpackage

// ### hw/uce_regs.sv
`timescale 1ns/100ps
// Operation
// - Masked error is neither logged nor reported upstream.
// - Mask bits are read-write, sticky, reset to zero.
// - Mask bits 16 to 20 writable; bits 14, 15 and 31 to 21 read zero.
// - Severity only matters for unmasked errors and alone picks class.
// - Unmasked error with severity set is reported fatal.
// - Unmasked error with severity clear is reported non-fatal.
// - Severity bits at 4,5,12,13,16,17,18,19,20.
// - Severity resets to one for 4,5,13,17,18; others zero; sticky.
// - Completion timeout severity bit 14 reads zero always.
// - Completer abort severity bit 15 reads zero always.
// - Legacy bit 0 is writable, sticky, and has no effect.
// - Each unmasked error of a type in EVT_IMPL sets a sticky write-one-to-clear status bit.
module uce_regs (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_cold_rst,
  input wire uce_pkg::uce_avmm_req_s i_avs_req,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire uce_pkg::uce_word_t i_err_evt,
  output uce_pkg::uce_report_s o_report,
  output logic o_irq
);
  import uce_pkg::*;

  // ****************************************
  // Bus slave
  // ****************************************
  uce_bus_e st_r;
  uce_bus_e st_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rd_mux;
  logic [31:0] be_mask;
  logic req;
  logic we;
  logic rd_ack;
  logic wait_r;
  uce_word_t mask_r;
  uce_word_t sev_r;
  wire uce_word_t sts_r;
  logic [IRQ_W-1:0] ists_r;
  logic [IRQ_W-1:0] imsk_r;
  logic [IRQ_W-1:0] ists_nxt;
  logic [IRQ_W-1:0] rc_clr;
  uce_report_s rep_r;
  uce_word_t live;
  logic warm;

  assign warm = i_rst | i_cold_rst;
  assign req = i_avs_req.read | i_avs_req.write;
  assign we = (st_r == UCE_ACK) & i_avs_req.write;
  assign rd_ack = (st_r == UCE_ACK) & i_avs_req.read;
  assign live = i_err_evt & EVT_IMPL & ~mask_r;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_be
      assign be_mask[8*gb +: 8] = {8{i_avs_req.byteenable[gb]}};
    end
  endgenerate

  // Request held in IDLE is answered one cycle later in ACK.
  always_comb begin
    case (st_r)
      UCE_IDLE: st_nxt = req ? UCE_ACK : UCE_IDLE;
      UCE_ACK: st_nxt = UCE_IDLE;
      default: st_nxt = UCE_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (warm) begin
      st_r <= UCE_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    case (i_avs_req.address)
      OFS_STATUS: rd_mux = sts_r;
      OFS_MASK: rd_mux = mask_r;
      OFS_SEV: rd_mux = sev_r;
      OFS_IRQ_STS: rd_mux = {30'h0000_0000, ists_r};
      OFS_IRQ_MSK: rd_mux = {30'h0000_0000, imsk_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is captured when the request is first seen, so it is
  // stable in the answer cycle.
  always_ff @(posedge i_core_clk) begin
    if (warm) begin
      rdata_r <= 32'h0000_0000;
    end else if (st_r == UCE_IDLE && i_avs_req.read) begin
      rdata_r <= rd_mux;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_avs_waitrequest = wait_r;

  // Waitrequest is registered from the next state, so the pin comes from a
  // flop and still drops in exactly the answer cycle.
  always_ff @(posedge i_core_clk) begin
    if (warm) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= (st_nxt != UCE_ACK);
    end
  end

  // ****************************************
  // Mask and severity
  // ****************************************
  // sticky mask
  always_ff @(posedge i_core_clk) begin
    if (i_cold_rst) begin
      mask_r <= MASK_RST;
    end else if (we && i_avs_req.address == OFS_MASK) begin
      mask_r <= ((mask_r & ~be_mask) | (i_avs_req.writedata & be_mask))
        & CTL_WMASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_cold_rst) begin
      sev_r <= SEV_RST;
    end else if (we && i_avs_req.address == OFS_SEV) begin
      sev_r <= ((sev_r & ~be_mask) | (i_avs_req.writedata & be_mask))
        & CTL_WMASK;
    end
  end

  // ****************************************
  // Status log
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_sts
      if (EVT_IMPL[gi]) begin : g_on
        logic bit_r;
        always_ff @(posedge i_core_clk) begin
          if (i_cold_rst) begin
            bit_r <= STS_RST[gi];
          end else if (live[gi]) begin
            bit_r <= 1'b1;
          end else if (we && i_avs_req.address == OFS_STATUS
                       && i_avs_req.writedata[gi] && be_mask[gi]) begin
            bit_r <= 1'b0;
          end
        end
        assign sts_r[gi] = bit_r;
      end else begin : g_off
        assign sts_r[gi] = STS_RST[gi];
      end
    end
  endgenerate

  // ****************************************
  // Upstream report
  // ****************************************
  // severity selects class
  always_ff @(posedge i_core_clk) begin
    if (warm) begin
      rep_r <= '0;
    end else begin
      rep_r.fatal <= |(live & sev_r);
      rep_r.nonfatal <= |(live & ~sev_r);
    end
  end

  assign o_report = rep_r;

  // ****************************************
  // Interrupt
  // ****************************************
  // Only bits that were returned are cleared, so an event landing after
  // the capture is kept.
  assign rc_clr = (rd_ack && i_avs_req.address == OFS_IRQ_STS)
    ? rdata_r[IRQ_W-1:0] : IRQ_RST;

  always_comb begin
    ists_nxt = ists_r & ~rc_clr;
    ists_nxt[IRQ_FATAL] = ists_nxt[IRQ_FATAL] | rep_r.fatal;
    ists_nxt[IRQ_NONFATAL] = ists_nxt[IRQ_NONFATAL] | rep_r.nonfatal;
  end

  always_ff @(posedge i_core_clk) begin
    if (warm) begin
      ists_r <= IRQ_RST;
    end else begin
      ists_r <= ists_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (warm) begin
      imsk_r <= IRQ_RST;
    end else if (we && i_avs_req.address == OFS_IRQ_MSK
                 && i_avs_req.byteenable[0]) begin
      imsk_r <= i_avs_req.writedata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (warm) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(ists_nxt & ~imsk_r);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_mask_no_log: assert property (@(posedge i_core_clk)
    disable iff (i_cold_rst)
    (live == 32'h0000_0000 && !we) |=> (sts_r == $past(sts_r)))
    else $error("masked error changed status");

  a_mask_cold_zero: assert property (@(posedge i_core_clk)
    i_cold_rst |=> (mask_r == MASK_RST))
    else $error("mask not zero after cold reset");

  a_mask_rsvd_zero: assert property (@(posedge i_core_clk)
    disable iff (i_cold_rst) (mask_r[31:21] == 11'h000))
    else $error("reserved mask bits set");

  a_quiet_no_rep: assert property (@(posedge i_core_clk)
    disable iff (warm)
    (live == 32'h0000_0000) |=> !o_report.fatal && !o_report.nonfatal)
    else $error("report without unmasked error");

  a_fatal_rep: assert property (@(posedge i_core_clk)
    disable iff (warm) (|(live & sev_r)) |=> o_report.fatal)
    else $error("fatal report missing");

  a_nonfatal_rep: assert property (@(posedge i_core_clk)
    disable iff (warm) (|(live & ~sev_r)) |=> o_report.nonfatal)
    else $error("non-fatal report missing");

  a_sev_layout: assert property (@(posedge i_core_clk)
    disable iff (i_cold_rst) ((sev_r & ~CTL_WMASK) == 32'h0000_0000))
    else $error("severity bit outside layout");

  a_sev_cold_def: assert property (@(posedge i_core_clk)
    i_cold_rst |=> (sev_r == SEV_RST))
    else $error("severity default wrong");

  a_cpl_to_zero: assert property (@(posedge i_core_clk)
    disable iff (i_cold_rst) !sev_r[BIT_CPL_TO])
    else $error("completion timeout severity set");

  a_abort_zero: assert property (@(posedge i_core_clk)
    disable iff (i_cold_rst) !sev_r[BIT_CPL_ABORT])
    else $error("completer abort severity set");

  a_legacy_inert: assert property (@(posedge i_core_clk)
    disable iff (warm)
    ((i_err_evt & EVT_IMPL) == 32'h0000_0000) |=> (o_report == '0))
    else $error("legacy bit caused report");

  a_status_set: assert property (@(posedge i_core_clk)
    disable iff (i_cold_rst)
    (live != 32'h0000_0000) |=> ((sts_r & $past(live)) == $past(live)))
    else $error("status not logged");

  a_warm_keeps: assert property (@(posedge i_core_clk)
    (i_rst && !i_cold_rst && !we) |=>
      (mask_r == $past(mask_r) && sev_r == $past(sev_r)))
    else $error("sticky field lost on warm reset");

  a_status_w1c: assert property (@(posedge i_core_clk)
    disable iff (i_cold_rst)
    (we && i_avs_req.address == OFS_STATUS && live == 32'h0000_0000
      && i_avs_req.byteenable == 4'hf)
    |=> ((sts_r & $past(i_avs_req.writedata)) == 32'h0000_0000))
    else $error("status bit not cleared");

  a_wait_pulse: assert property (@(posedge i_core_clk)
    disable iff (warm)
    !o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");

  a_rdata_rsvd: assert property (@(posedge i_core_clk)
    disable iff (warm)
    rd_ack |-> (o_avs_readdata[31:21] == 11'h000))
    else $error("reserved read bits set");

endmodule // uce_regs

// ### dv/uce_rc_model.sv
`timescale 1ns/100ps
// ****************************************
// Upstream receiver of error messages
// ****************************************
module uce_rc_model (
  input wire logic i_core_clk,
  input wire uce_pkg::uce_report_s i_report,
  output int o_fatal_cnt,
  output int o_nonfatal_cnt
);
  import uce_pkg::*;
  initial begin
    o_fatal_cnt = 0;
    o_nonfatal_cnt = 0;
  end
  // Each high cycle is one message, so a stuck output counts many times.
  always @(posedge i_core_clk) begin
    if (i_report.fatal === 1'b1) o_fatal_cnt <= o_fatal_cnt + 1;
    if (i_report.nonfatal === 1'b1) o_nonfatal_cnt <= o_nonfatal_cnt + 1;
  end
endmodule // uce_rc_model

// ### dv/tb.sv
`timescale 1ns/100ps
module tb;
  import uce_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic cold = 1;
  uce_avmm_req_s req = '0;
  uce_word_t evt = '0;
  logic [3:0] be_sel = 4'hf;
  logic [31:0] rdata;
  logic wr;
  logic irq;
  uce_report_s rep;
  int errors = 0;
  int samples_checked = 0;
  int nf;
  int nn;

  always #12.5 clk = ~clk;

  uce_regs uce_regs_inst (.i_core_clk(clk), .i_rst(rst), .i_cold_rst(cold),
    .i_avs_req(req), .o_avs_readdata(rdata), .o_avs_waitrequest(wr),
    .i_err_evt(evt), .o_report(rep), .o_irq(irq));
  uce_rc_model uce_rc_model_inst (.i_core_clk(clk), .i_report(rep),
    .o_fatal_cnt(nf), .o_nonfatal_cnt(nn));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Entered right after a rising edge; ends one edge after the release.
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    req.read <= !w;
    req.write <= w;
    req.address <= a;
    req.byteenable <= be_sel;
    req.writedata <= d;
    do begin
      @(posedge clk);
    end while (wr !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    check(q, exp);
  endtask

  task automatic pulse(input uce_word_t b, input int ef, input int en);
    int f0;
    int n0;
    f0 = nf;
    n0 = nn;
    evt <= b;
    @(posedge clk);
    evt <= '0;
    repeat (3) @(posedge clk);
    check(nf - f0, ef);
    check(nn - n0, en);
  endtask

  task automatic rs(input logic c);
    rst <= 1'b1;
    cold <= c;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cold <= 1'b0;
    @(posedge clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_fields;
    rchk(OFS_MASK, 32'h0000_0000);
    rchk(OFS_SEV, 32'h0006_2030);
    wr32(OFS_MASK, 32'hFFFF_FFFF);
    rchk(OFS_MASK, 32'h001F_3031);
    be_sel = 4'h4;
    wr32(OFS_MASK, 32'h0000_0000);
    be_sel = 4'hf;
    rchk(OFS_MASK, 32'h0000_3031);
    wr32(OFS_SEV, 32'hFFFF_FFFF);
    rchk(OFS_SEV, 32'h001F_3031);
    wr32(12'h300, 32'hFFFF_FFFF);
    rchk(12'h300, 32'h0000_0000);
  endtask

  task automatic t_severity;
    wr32(OFS_MASK, 32'h0000_0000);
    for (int b = 0; b < 32; b++) begin
      if (EVT_IMPL[b]) pulse(32'h0000_0001 << b, 1, 0);
    end
    wr32(OFS_SEV, 32'h0000_0001);
    for (int b = 0; b < 32; b++) begin
      if (EVT_IMPL[b]) pulse(32'h0000_0001 << b, 0, 1);
    end
    pulse(32'h0000_C000, 0, 0);
    rchk(OFS_STATUS, 32'h001F_3030);
    wr32(OFS_STATUS, 32'h0010_0000);
    rchk(OFS_STATUS, 32'h000F_3030);
    wr32(OFS_STATUS, 32'hFFFF_FFFF);
  endtask

  task automatic t_mask;
    wr32(OFS_MASK, 32'h001F_3030);
    wr32(OFS_SEV, 32'h0008_0000);
    pulse(32'h001F_3030, 0, 0);
    rchk(OFS_STATUS, 32'h0000_0000);
    wr32(OFS_MASK, 32'h0017_3030);
    pulse(32'h001F_3030, 1, 0);
  endtask

  task automatic t_irq;
    rchk(OFS_IRQ_STS, 32'h0000_0003);
    wr32(OFS_MASK, 32'h0000_0000);
    wr32(OFS_SEV, 32'h0000_0000);
    pulse(32'h0010_0000, 0, 1);
    check(irq, 1'b1);
    rchk(OFS_IRQ_STS, 32'h0000_0002);
    @(posedge clk);
    check(irq, 1'b0);
    wr32(OFS_IRQ_MSK, 32'h0000_0002);
    pulse(32'h0010_0000, 0, 1);
    check(irq, 1'b0);
    rchk(OFS_IRQ_STS, 32'h0000_0002);
  endtask

  task automatic t_sticky;
    wr32(OFS_MASK, 32'h0010_0001);
    wr32(OFS_SEV, 32'h0000_0001);
    rs(1'b0);
    rchk(OFS_MASK, 32'h0010_0001);
    rchk(OFS_SEV, 32'h0000_0001);
    rchk(OFS_STATUS, 32'h0018_0000);
    rs(1'b1);
    rchk(OFS_MASK, 32'h0000_0000);
    rchk(OFS_SEV, 32'h0006_2030);
    rchk(OFS_STATUS, 32'h0000_0000);
  endtask

  task automatic print_verdict;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200us;
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cold <= 1'b0;
    @(posedge clk);
    t_fields();
    t_severity();
    t_mask();
    t_irq();
    t_sticky();
    print_verdict();
  end
endmodule // tb
